// ===== rtl/sapb_ctrl.sv
// Stand-alone brightness controller: one PWM input sets RGB LED levels
//
// Overview of operation
// (R1) Ready for stand-alone after reset, no setup
// (R2) Rising edge on brightness input enters mode
// (R3) Only the brightness input controls the mode
// (R4) Boost uses adaptive output voltage in mode
// (R5) Load RGB currents from calibration memory
// (R6) Brightness follows input PWM waveform
// (R7) Host keeps PWM between 2 and 10 kHz
// (R8) Example: 2 kHz PWM with 8 steps
// (R9) Measure duty each period, scale all channels
`include "sapb_params.svh"

module sapb_ctrl (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Brightness input from host
   input wire logic brightness_pwm_input,
   // Calibration memory interface
   output logic cal_rd_req,
   input wire logic cal_rd_done,
   input wire sapb_pkg::sapb_cur_t cal_red,
   input wire sapb_pkg::sapb_cur_t cal_green,
   input wire sapb_pkg::sapb_cur_t cal_blue,
   // Mode and boost control
   output logic standalone_active,
   output logic boost_adaptive_en,
   // Measured duty and scaled channel levels
   output sapb_pkg::sapb_duty_t duty_level,
   output sapb_pkg::sapb_cur_t led_red,
   output sapb_pkg::sapb_cur_t led_green,
   output sapb_pkg::sapb_cur_t led_blue,
   // Direct channel enables follow the input waveform in the mode only
   output logic led_on
);
   import sapb_pkg::*;

   // Scale a calibrated current by the measured duty
   // Full duty returns the current exactly, so a solid-high input loses nothing
   function automatic sapb_cur_t scale_cur(input sapb_cur_t cur, input sapb_duty_t duty);
      logic [15:0] prod;
      prod = 16'(cur) * 16'(duty);
      if (duty == `SAPB_DUTY_FULL) begin
         return cur;
      end
      return prod[15:8];
   endfunction : scale_cur

   // Mode decode shared by the counters, the channels and the outputs
   function automatic logic in_run(input sapb_state_t st);
      return (st == SAPB_RUN);
   endfunction : in_run

   // Calibration fetch in progress
   function automatic logic in_load(input sapb_state_t st);
      return (st == SAPB_LOAD);
   endfunction : in_load

   // Mode state
   sapb_state_t state_q;
   sapb_state_t state_d;
   // Input edge detector
   logic pwm_prev_q;
   logic pwm_prev_d;
   logic rise;
   // Period and high-time counters
   logic [`SAPB_CNT_W-1:0] period_q;
   logic [`SAPB_CNT_W-1:0] period_d;
   logic [`SAPB_CNT_W-1:0] high_q;
   logic [`SAPB_CNT_W-1:0] high_d;
   // Duty divider and duty register
   logic [`SAPB_CNT_W+7:0] duty_num;
   logic [`SAPB_CNT_W+7:0] duty_quo;
   sapb_duty_t duty_new;
   sapb_duty_t duty_q;
   sapb_duty_t duty_d;
   // Period events
   logic run_now;
   logic load_done;
   logic period_end;
   logic long_ok;
   logic stuck;
   // Channel inputs and levels
   sapb_cur_t cal_in [3];
   sapb_cur_t lvl_out [3];
   // Direct channel enable
   logic led_on_q;
   logic led_on_d;

   // Calibration words gathered so the channels can be generated
   assign cal_in[0] = cal_red;
   assign cal_in[1] = cal_green;
   assign cal_in[2] = cal_blue;

   // Edge detector; reset to the idle low level of the pin, so a host that
   // already holds the line high at release is taken as a rising edge
   always_comb begin
      pwm_prev_d = brightness_pwm_input;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pwm_prev_q <= 1'b0;
      end else begin
         pwm_prev_q <= pwm_prev_d;
      end
   end

   assign rise = brightness_pwm_input & ~pwm_prev_q; // [R2]

   // Mode state machine; no serial setup is ever needed to leave idle [R1]
   always_comb begin
      state_d = state_q;
      case (state_q)
         // Only the brightness input can start the mode [R3]
         SAPB_IDLE: begin
            if (rise) begin
               state_d = SAPB_LOAD; // [R2]
            end
         end
         // Hold the fetch request until the memory answers [R5]
         SAPB_LOAD: begin
            if (cal_rd_done) begin
               state_d = SAPB_RUN;
            end
         end
         // Mode is left only through reset
         SAPB_RUN: begin
            state_d = SAPB_RUN;
         end
         default: begin
            state_d = SAPB_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_q <= SAPB_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Period events
   assign run_now = in_run(state_q);
   assign load_done = in_load(state_q) & cal_rd_done; // [R5]
   assign period_end = run_now & rise; // [R9]
   // Periods more than one cycle shorter than the fastest legal PWM are ignored
   assign long_ok = (period_q >= 16'(`SAPB_PERIOD_MIN_CYC - 1));
   // No edge for a whole slowest period: the input is parked
   assign stuck = run_now & ~rise & (period_q >= 16'(`SAPB_PERIOD_MAX_CYC));

   // Period and high-time counters; a rise restarts both at one because
   // the rising cycle is itself a high cycle of the new period
   always_comb begin
      period_d = period_q;
      high_d = high_q;
      if (load_done) begin
         period_d = '0;
         high_d = '0;
      end else if (period_end) begin
         period_d = 16'h0001;
         high_d = 16'h0001;
      end else if (stuck) begin
         period_d = '0;
         high_d = '0;
      end else if (run_now) begin
         period_d = period_q + 16'h0001;
         high_d = high_q + (brightness_pwm_input ? 16'h0001 : 16'h0000);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         period_q <= '0;
         high_q <= '0;
      end else begin
         period_q <= period_d;
         high_q <= high_d;
      end
   end

   // Duty = high * 255 / period; the divider is combinational and wide, a
   // trade of area for a result that is ready in the cycle of the rise
   assign duty_num = {high_q, 8'h00} - {8'h00, high_q};
   assign duty_quo = (period_q == '0) ? '0 : duty_num / {8'h00, period_q};
   // High time never exceeds the period, so the quotient fits eight bits
   assign duty_new = duty_quo[7:0];

   // Duty register: updated at each long enough period, or forced when parked
   always_comb begin
      duty_d = duty_q;
      if (period_end && long_ok) begin
         duty_d = duty_new; // [R9]
      end else if (stuck) begin
         duty_d = brightness_pwm_input ? `SAPB_DUTY_FULL : 8'h00; // [R6]
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         duty_q <= 8'h00;
      end else begin
         duty_q <= duty_d;
      end
   end

   // One current register and one level register per colour channel
   for (genvar ch = 0; ch < 3; ch++) begin : g_chan
      sapb_cur_t cur_q;
      sapb_cur_t cur_d;
      sapb_cur_t lvl_q;
      sapb_cur_t lvl_d;

      // Capture the calibrated current, scale it at each long enough period end
      always_comb begin
         cur_d = cur_q;
         lvl_d = lvl_q;
         if (load_done) begin
            cur_d = cal_in[ch]; // [R5]
         end
         if (period_end && long_ok) begin
            lvl_d = scale_cur(cur_q, duty_new); // [R9]
         end else if (stuck) begin
            lvl_d = brightness_pwm_input ? cur_q : 8'h00; // [R6]
         end
      end

      always_ff @(posedge mclk) begin
         if (sys_rst) begin
            cur_q <= 8'h00;
            lvl_q <= 8'h00;
         end else begin
            cur_q <= cur_d;
            lvl_q <= lvl_d;
         end
      end

      assign lvl_out[ch] = lvl_q;
   end

   // Channel enable copies the input one cycle late, dark outside the mode
   always_comb begin
      led_on_d = run_now ? brightness_pwm_input : 1'b0; // [R6]
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         led_on_q <= 1'b0;
      end else begin
         led_on_q <= led_on_d;
      end
   end

   // Outputs
   assign cal_rd_req = in_load(state_q); // [R5]
   assign standalone_active = run_now;
   assign boost_adaptive_en = run_now; // [R4]
   assign duty_level = duty_q;
   assign led_red = lvl_out[0];
   assign led_green = lvl_out[1];
   assign led_blue = lvl_out[2];
   assign led_on = led_on_q;
endmodule : sapb_ctrl

// ===== rtl/sapb_params.svh
// Constants for the stand-alone PWM brightness controller
`ifndef SAPB_PARAMS_SVH
`define SAPB_PARAMS_SVH

// Clock rate in kHz and brightness input frequency window in kHz
`define SAPB_CLK_KHZ 40000
`define SAPB_PWM_MIN_KHZ 2
`define SAPB_PWM_MAX_KHZ 10
// Longest legal period in cycles (2 kHz), rounded down
`define SAPB_PERIOD_MAX_CYC (`SAPB_CLK_KHZ / `SAPB_PWM_MIN_KHZ)
// Shortest legal period in cycles (10 kHz)
`define SAPB_PERIOD_MIN_CYC (`SAPB_CLK_KHZ / `SAPB_PWM_MAX_KHZ)
// Widths
`define SAPB_CNT_W 16
`define SAPB_CUR_W 8
`define SAPB_DUTY_W 8
// Full-scale duty value
`define SAPB_DUTY_FULL 8'hFF

`endif

// ===== rtl/sapb_pkg.sv
// Types for the stand-alone PWM brightness controller
package sapb_pkg;
   typedef enum logic [1:0] {
      SAPB_IDLE,
      SAPB_LOAD,
      SAPB_RUN
   } sapb_state_t;
   typedef logic [7:0] sapb_cur_t;
   typedef logic [7:0] sapb_duty_t;
endpackage : sapb_pkg

// ===== testbench/sapb_host.sv
// Host model driving the brightness PWM toward the device
module sapb_host (
   // Clock and waveform setup, pwm toward the device
   input wire logic mclk,
   input wire logic [31:0] per,
   input wire logic [31:0] hi,
   output logic pwm
);
   timeunit 1ns;
   timeprecision 1ps;
   int cnt = 0;
   initial pwm = 1'b0;
   // Period of per cycles, high for hi; hi above per holds the line high
   always @(negedge mclk) begin
      cnt <= (cnt >= per - 1) ? 0 : cnt + 1;
      pwm <= (cnt < hi);
   end
endmodule : sapb_host

// ===== testbench/sapb_chk.sv
// Port assertions for the brightness controller
module sapb_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Watched ports
   input wire logic brightness_pwm_input,
   input wire logic cal_rd_req,
   input wire logic cal_rd_done,
   input wire logic standalone_active,
   input wire logic boost_adaptive_en,
   input wire logic led_on,
   input wire sapb_pkg::sapb_duty_t duty_level,
   input wire sapb_pkg::sapb_cur_t led_red
);
   import sapb_pkg::*;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   rise_load_a: assert property (!cal_rd_req && !standalone_active &&
      brightness_pwm_input && !$past(brightness_pwm_input) |=> cal_rd_req) else $error("no load");
   load_run_a: assert property (cal_rd_req && cal_rd_done |=> standalone_active)
      else $error("no run");
   req_hold_a: assert property (cal_rd_req && !cal_rd_done |=> cal_rd_req)
      else $error("req dropped");
   run_stays_a: assert property (standalone_active |=> standalone_active)
      else $error("run left");
   boost_mode_a: assert property (boost_adaptive_en == standalone_active)
      else $error("boost mode");
   led_follow_a: assert property (standalone_active && $past(standalone_active) |->
      led_on == $past(brightness_pwm_input)) else $error("led_on lag");
   idle_dark_a: assert property (!standalone_active |-> !led_on && duty_level == 8'h00)
      else $error("idle not dark");
   level_hold_a: assert property ($stable(duty_level) |-> $stable(led_red))
      else $error("level moved");
   // Main scenarios reached
   cover property (cal_rd_req && cal_rd_done);
   cover property (led_on && standalone_active);
   cover property (duty_level == 8'hFF);
endmodule : sapb_chk
bind sapb_ctrl sapb_chk u_chk (.*);

// ===== testbench/sapb_ctrl_tb.sv
// Self-checking bench for the brightness controller
module sapb_ctrl_tb;
   import sapb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0, sys_rst = 1'b1, brightness_pwm_input, cal_rd_req, cal_rd_done = 1'b0;
   logic standalone_active, boost_adaptive_en, led_on;
   sapb_cur_t cal_red = 8'h00, cal_green = 8'h00, cal_blue = 8'h00, led_red, led_green, led_blue;
   sapb_duty_t duty_level;
   int per = 4000, hi = 0, cyc = 0, error_cnt = 0, checks = 0;
   sapb_host u_host (.mclk(mclk), .per(per), .hi(hi), .pwm(brightness_pwm_input));
   sapb_ctrl u_dut (.*);
   initial forever #12.5 mclk = ~mclk;
   // Hang guard, traffic needs about 100k cycles
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 115000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic check(string n, logic [7:0] s, logic [7:0] e);
      checks++;
      if (s !== e) begin
         error_cnt++;
         $display("FAIL %s exp %h got %h", n, e, s);
      end
   endtask : check
   // Full duty passes the current untouched
   function automatic logic [7:0] lvl(logic [7:0] c, logic [7:0] d);
      return (d == 8'hFF) ? c : 8'((16'(c) * d) >> 8);
   endfunction : lvl
   // Two periods give one clean measured period
   task automatic run(int p, int h);
      logic [7:0] d;
      d = (h >= p) ? 8'hFF : 8'(h * 255 / p);
      per = p;
      hi = h;
      repeat (2 * p + 8) @(negedge mclk);
      check("duty", duty_level, d);
      check("red", led_red, lvl(cal_red, d));
      check("green", led_green, lvl(cal_green, d));
      check("blue", led_blue, lvl(cal_blue, d));
      $display("test %0d of %0d done", h, p);
   endtask : run
   // Wait for the load request, answer it late, then expect the mode
   task automatic enter();
      for (int i = 0; i < 4600 && cal_rd_req !== 1'b1; i++) @(negedge mclk);
      check("req", cal_rd_req, 1'b1);
      repeat (2) @(negedge mclk);
      cal_rd_done = 1'b1;
      @(negedge mclk);
      cal_rd_done = 1'b0;
      @(negedge mclk);
      check("run", standalone_active, 1'b1);
      check("boost", boost_adaptive_en, 1'b1);
   endtask : enter
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   initial begin
      void'($urandom(32'h32d2cf24));
      repeat (12) @(negedge mclk);
      sys_rst = 1'b0;
      cal_red = 8'($urandom);
      cal_green = 8'($urandom);
      cal_blue = 8'hFF;
      check("idle", standalone_active, 1'b0);
      hi = 2000;
      enter();
      for (int k = 0; k < 8; k++) run(4000, (2 * k + 1) * 250);
      // Too fast a PWM is not measured: the last step stays in force
      per = 2000;
      hi = 1000;
      repeat (4008) @(negedge mclk);
      check("fast duty", duty_level, 8'(3750 * 255 / 4000));
      check("fast red", led_red, lvl(cal_red, 8'(3750 * 255 / 4000)));
      $display("test fast pwm done");
      per = 4000 + $urandom % 500;
      run(per, 1 + $urandom % (per - 1));
      // Reset in mid-run drops back to a dark idle, then the mode returns
      sys_rst = 1'b1;
      repeat (2) @(negedge mclk);
      sys_rst = 1'b0;
      check("rst mode", standalone_active, 1'b0);
      check("rst duty", duty_level, 8'h00);
      check("rst red", led_red, 8'h00);
      enter();
      run(10500, 10501);
      print_verdict();
   end
endmodule : sapb_ctrl_tb
